// *** logic/zero_flag_defines.svh ***
`ifndef ZERO_FLAG_DEFINES_SVH
`define ZERO_FLAG_DEFINES_SVH

// Register map on the plain register port (word index).
`define ADDR_CTRL 4'h0
`define ADDR_GPIO 4'h1
`define ADDR_STAT 4'h2
`define ADDR_IRQ_STATUS 4'h3
`define ADDR_IRQ_MASK 4'h4
`define ADDR_W 4

// Control register fields.
`define CTRL_OVERSAMPLE_BIT 0
`define CTRL_POLARITY_BIT 1
`define CTRL_GP_ENABLE_BIT 2
`define CTRL_CLK_MODE_LSB 3
`define CTRL_RESET 16'h0000

// Counts.
`define NUM_CHAN 8
`define NUM_GP 6
`define ZERO_RUN_LEN 11'd1024
`define ZERO_CNT_W 11
`define SAMPLE_W 24
`define DATA_W 16

`endif

// *** logic/zero_flag_pkg.sv ***
package zero_flag_pkg;
   typedef enum logic [1:0] {
      ratio_low,
      ratio_high
   } clk_ratio_t;
   typedef enum logic [1:0] {
      os_32x = 2'h0,
      os_64x = 2'h1,
      os_128x = 2'h2
   } os_rate_t;
endpackage

// *** logic/zero_run_counter.sv ***
`timescale 1ns/100ps
`include "zero_flag_defines.svh"

module zero_run_counter (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sample_tick,
   input wire logic [`SAMPLE_W-1:0] sample,
   output logic zero_cond
);
   logic [`ZERO_CNT_W-1:0] count_reg;

   // A nonzero sample restarts the run at once; the count saturates at the threshold.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         count_reg <= '0;
      end else if (sample_tick) begin
         if (sample != '0) begin
            count_reg <= '0;
         end else if (count_reg != `ZERO_RUN_LEN) begin
            count_reg <= count_reg + `ZERO_CNT_W'(1);
         end
      end
   end

   assign zero_cond = (count_reg == `ZERO_RUN_LEN);

   run_restart_a: assert property (@(posedge mclk) disable iff (!rst_n)
      sample_tick && sample != '0 |=> !zero_cond) else $error("zero run not restarted");
   run_saturate_a: assert property (@(posedge mclk) disable iff (!rst_n)
      zero_cond && sample_tick && sample == '0 |=> zero_cond) else $error("zero run dropped");
endmodule

// *** logic/zero_flag_gp.sv ***
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/100ps
`include "zero_flag_defines.svh"

module zero_flag_gp
   import zero_flag_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sample_word_clock,
   input wire logic [`NUM_CHAN*`SAMPLE_W-1:0] chan_samples,
   input wire logic [`ADDR_W-1:0] addr,
   input wire logic [`DATA_W-1:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [`DATA_W-1:0] rdata,
   output logic [`NUM_CHAN-1:0] flag_pins,
   output logic all_chan_flag,
   output logic [1:0] os_rate,
   output logic irq
);
   import zero_flag_pkg::*;

   // ==========================================================
   // Sample clock synchroniser and tick
   // ==========================================================
   logic wc_meta_reg;
   logic wc_sync_reg;
   logic wc_prev_reg;
   logic sample_tick;
   logic [`NUM_CHAN*`SAMPLE_W-1:0] samp_meta_reg;
   logic [`NUM_CHAN*`SAMPLE_W-1:0] samp_sync_reg;

   // Samples are held stable across a word clock edge, so a two-stage sync suffices.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wc_meta_reg <= 1'b0;
         wc_sync_reg <= 1'b0;
         wc_prev_reg <= 1'b0;
         samp_meta_reg <= '0;
         samp_sync_reg <= '0;
      end else begin
         wc_meta_reg <= sample_word_clock;
         wc_sync_reg <= wc_meta_reg;
         wc_prev_reg <= wc_sync_reg;
         samp_meta_reg <= chan_samples;
         samp_sync_reg <= samp_meta_reg;
      end
   end

   assign sample_tick = wc_sync_reg && !wc_prev_reg;

   // ==========================================================
   // Per-channel zero-run detectors
   // ==========================================================
   logic [`NUM_CHAN-1:0] zero_cond;

   genvar ch;
   generate
      for (ch = 0; ch < `NUM_CHAN; ch = ch + 1) begin : g_chan
         zero_run_counter u_cnt (
            .mclk(mclk),
            .rst_n(rst_n),
            .sample_tick(sample_tick),
            .sample(samp_sync_reg[ch*`SAMPLE_W +: `SAMPLE_W]),
            .zero_cond(zero_cond[ch])
         );
      end
   endgenerate

   // ==========================================================
   // Registers
   // ==========================================================
   logic oversample_reg;
   logic polarity_reg;
   logic gp_out_enable;
   logic clk_ratio_reg;
   logic [`NUM_GP-1:0] gp_out_value;
   logic [`NUM_CHAN:0] irq_status_reg;
   logic [`NUM_CHAN:0] irq_mask_reg;
   logic [`NUM_CHAN:0] zero_prev_reg;
   logic [`NUM_CHAN:0] zero_all;
   logic [`NUM_CHAN:0] zero_rise;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         oversample_reg <= 1'b0;
         polarity_reg <= 1'b0;
         gp_out_enable <= 1'b0;
         clk_ratio_reg <= 1'b0;
      end else if (wr_stb && addr == `ADDR_CTRL) begin
         oversample_reg <= wdata[`CTRL_OVERSAMPLE_BIT];
         polarity_reg <= wdata[`CTRL_POLARITY_BIT];
         gp_out_enable <= wdata[`CTRL_GP_ENABLE_BIT];
         clk_ratio_reg <= wdata[`CTRL_CLK_MODE_LSB];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         gp_out_value <= '0;
      end else if (wr_stb && addr == `ADDR_GPIO) begin
         gp_out_value <= wdata[`NUM_GP-1:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         irq_mask_reg <= '0;
      end else if (wr_stb && addr == `ADDR_IRQ_MASK) begin
         irq_mask_reg <= wdata[`NUM_CHAN:0];
      end
   end

   // Events are the onset of each zero condition and of the all-channel condition.
   assign zero_all = {&zero_cond, zero_cond};
   assign zero_rise = zero_all & ~zero_prev_reg;

   // A new event in the clearing cycle survives, since set is ORed after the clear.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         zero_prev_reg <= '0;
         irq_status_reg <= '0;
      end else begin
         zero_prev_reg <= zero_all;
         if (wr_stb && addr == `ADDR_IRQ_STATUS) begin
            irq_status_reg <= (irq_status_reg & ~wdata[`NUM_CHAN:0]) | zero_rise;
         end else begin
            irq_status_reg <= irq_status_reg | zero_rise;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status_reg & irq_mask_reg);
      end
   end

   // Unmapped addresses read as zero.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rdata <= '0;
      end else if (rd_stb) begin
         case (addr)
            `ADDR_CTRL: rdata <= {12'h000, clk_ratio_reg, gp_out_enable, polarity_reg, oversample_reg};
            `ADDR_GPIO: rdata <= {10'h000, gp_out_value};
            `ADDR_STAT: rdata <= {7'h00, zero_all};
            `ADDR_IRQ_STATUS: rdata <= {7'h00, irq_status_reg};
            `ADDR_IRQ_MASK: rdata <= {7'h00, irq_mask_reg};
            default: rdata <= '0;
         endcase
      end else begin
         rdata <= '0;
      end
   end

   // ==========================================================
   // Oversampling selection
   // ==========================================================
   clk_ratio_t ratio;
   assign ratio = clk_ratio_reg ? ratio_high : ratio_low;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         os_rate <= os_32x;
      end else begin
         case (ratio)
            ratio_low: os_rate <= oversample_reg ? os_64x : os_32x;
            ratio_high: os_rate <= oversample_reg ? os_128x : os_64x;
            default: os_rate <= os_64x;
         endcase
      end
   end

   // ==========================================================
   // Flag pins
   // ==========================================================
   logic [`NUM_CHAN-1:0] flag_level;
   assign flag_level = zero_cond ^ {`NUM_CHAN{polarity_reg}};

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         flag_pins <= '0;
         all_chan_flag <= 1'b0;
      end else begin
         flag_pins[`NUM_CHAN-1:`NUM_GP] <= flag_level[`NUM_CHAN-1:`NUM_GP];
         flag_pins[`NUM_GP-1:0] <= gp_out_enable ? gp_out_value : flag_level[`NUM_GP-1:0];
         all_chan_flag <= (&zero_cond) ^ polarity_reg;
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   gp_pins_a: assert property (@(posedge mclk) disable iff (!rst_n)
      gp_out_enable |=> flag_pins[`NUM_GP-1:0] == $past(gp_out_value)) else $error("gp pins wrong");
   zero_pins_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !gp_out_enable |=> flag_pins[`NUM_GP-1:0] == $past(flag_level[`NUM_GP-1:0])) else $error("flag pins wrong");
   upper_flags_a: assert property (@(posedge mclk) disable iff (!rst_n)
      1'b1 |=> flag_pins[7] == ($past(zero_cond[7]) ^ $past(polarity_reg))) else $error("flag 8 wrong");
   all_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
      1'b1 |=> all_chan_flag == ((&$past(zero_cond)) ^ $past(polarity_reg))) else $error("all flag wrong");
   pol_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
      polarity_reg && zero_cond[0] && !gp_out_enable |=> !flag_pins[0]) else $error("inverted flag not low");
   pol_all_a: assert property (@(posedge mclk) disable iff (!rst_n)
      polarity_reg && (&zero_cond) |=> !all_chan_flag) else $error("all flag not inverted");
   pol_reset_a: assert property (@(posedge mclk)
      !rst_n |=> !polarity_reg) else $error("polarity not reset");
   gp_reset_a: assert property (@(posedge mclk)
      !rst_n |=> gp_out_value == '0 && !gp_out_enable) else $error("gp not reset");
   os_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !clk_ratio_reg |=> os_rate == ($past(oversample_reg) ? os_64x : os_32x)) else $error("os low wrong");
   os_high_a: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_ratio_reg |=> os_rate == ($past(oversample_reg) ? os_128x : os_64x)) else $error("os high wrong");
   flag_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
      zero_cond[1] && !sample_tick |=> zero_cond[1]) else $error("zero condition lost");

   // ==========================================================
   // Sample tick, register port, flag pin and interrupt checks
   // ==========================================================
   // The edge detector must never fire twice in a row, or one word clock would count as two samples.
   tick_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
      sample_tick |=> !sample_tick) else $error("sample tick too long");
   gp_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wr_stb && addr == `ADDR_GPIO |=> gp_out_value == $past(wdata[`NUM_GP-1:0])) else $error("gp write lost");
   pol_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wr_stb && addr == `ADDR_CTRL |=> polarity_reg == $past(wdata[`CTRL_POLARITY_BIT])) else $error("pol write lost");
   flag_seven_a: assert property (@(posedge mclk) disable iff (!rst_n)
      1'b1 |=> flag_pins[6] == ($past(zero_cond[6]) ^ $past(polarity_reg))) else $error("flag 7 wrong");
   irq_level_a: assert property (@(posedge mclk) disable iff (!rst_n)
      1'b1 |=> irq == (|$past(irq_status_reg & irq_mask_reg))) else $error("irq level wrong");
   status_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
      1'b1 |=> (irq_status_reg & $past(zero_rise)) == $past(zero_rise)) else $error("event lost");
   status_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !(wr_stb && addr == `ADDR_IRQ_STATUS) |=> (irq_status_reg & $past(irq_status_reg)) == $past(irq_status_reg))
      else $error("status bit dropped");
   rdata_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !rd_stb |=> rdata == '0) else $error("read data not idle");
   rdata_stat_a: assert property (@(posedge mclk) disable iff (!rst_n)
      rd_stb && addr == `ADDR_STAT |=> rdata == {7'h00, $past(zero_all)}) else $error("status read wrong");
endmodule

// *** sim/sample_source.sv ***
`timescale 1ns/100ps
`include "zero_flag_defines.svh"
// ========================================
// Sample source on the far side
// The word clock stands still low between bursts; a started period always completes.
module sample_source (
   input wire logic mclk,
   input wire logic run,
   input wire logic slow,
   input wire logic [`NUM_CHAN-1:0] zero_ch,
   input wire logic [`SAMPLE_W-1:0] nz_val,
   output logic sample_word_clock,
   output logic [`NUM_CHAN*`SAMPLE_W-1:0] chan_samples
);
   logic [3:0] ph = 4'h0;
   initial sample_word_clock = 1'b0;
   initial chan_samples = '0;
   always @(posedge mclk) begin
      // Samples only change in the low phase, so they are steady around the rising edge.
      if (!sample_word_clock && ph == 4'h0) begin
         for (int c = 0; c < `NUM_CHAN; c++)
            chan_samples[c*`SAMPLE_W +: `SAMPLE_W] <= zero_ch[c] ? '0 : nz_val;
      end
      if (run || sample_word_clock) begin
         ph <= ph + 4'h1;
         if (ph == (slow ? 4'h7 : 4'h3)) begin
            ph <= 4'h0;
            sample_word_clock <= !sample_word_clock;
         end
      end
   end
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/100ps
`include "zero_flag_defines.svh"
// ========================================
// Bench top
module tb_top;
   import zero_flag_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic run = 1'b0;
   logic slow = 1'b0;
   logic [7:0] zero_ch = 8'h7F;
   logic [23:0] nz_val = 24'h000001;
   logic wclk;
   logic [`NUM_CHAN*`SAMPLE_W-1:0] smp;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic rd_q = 1'b0;
   logic [15:0] rdata;
   logic [7:0] pins;
   logic all_f;
   logic [1:0] os_rate;
   logic irq;
   logic [15:0] exp_q[$];
   logic [5:0] gpv;
   int err_count = 0;
   int n_compared = 0;
   int seed = 19;
   int cyc = 0;
   always #12.5 mclk = ~mclk;
   sample_source src_u (.mclk(mclk), .run(run), .slow(slow), .zero_ch(zero_ch), .nz_val(nz_val),
      .sample_word_clock(wclk), .chan_samples(smp));
   zero_flag_gp dut_u (.mclk(mclk), .rst_n(rst_n), .sample_word_clock(wclk), .chan_samples(smp),
      .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .flag_pins(pins), .all_chan_flag(all_f), .os_rate(os_rate), .irq(irq));
   // ========================================
   // Tasks
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // A read passes its expected value as d; the monitor compares it a cycle later.
   task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr_stb <= w;
      rd_stb <= !w;
      if (!w) exp_q.push_back(d);
      @(posedge mclk);
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic ticks(input int n);
      @(posedge mclk);
      run <= 1'b1;
      repeat (n) @(posedge wclk);
      run <= 1'b0;
      idle(12);
   endtask
   // ========================================
   // Monitor and timeout
   always @(posedge mclk) begin
      rd_q <= rd_stb;
      cyc <= cyc + 1;
      if (rd_q) chk("rdata", rdata, exp_q.pop_front());
      if (cyc == 45000) begin
         err_count++;
         test_done();
      end
   end
   // ========================================
   // Main sequence
   initial begin
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      idle(2);
      chk("os_rate", {14'h0, os_rate}, 16'h0000);
      chk("flags", {7'h0, all_f, pins}, 16'h0000);
      bus(1'b0, `ADDR_CTRL, `CTRL_RESET);
      bus(1'b0, `ADDR_GPIO, 16'h0000);
      bus(1'b0, 4'hF, 16'h0000);
      $display("test reset done");
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, `ADDR_CTRL, 16'((m % 2) << `CTRL_OVERSAMPLE_BIT) | 16'((m / 2) << `CTRL_CLK_MODE_LSB));
         idle(3);
         chk("os_rate", {14'h0, os_rate}, 16'((m / 2) + (m % 2)));
      end
      $display("test oversample done");
      gpv = 6'($random(seed));
      bus(1'b1, `ADDR_GPIO, {10'h0, gpv});
      bus(1'b1, `ADDR_CTRL, 16'(1 << `CTRL_GP_ENABLE_BIT));
      idle(3);
      chk("gp pins", {10'h0, pins[5:0]}, {10'h0, gpv});
      bus(1'b0, `ADDR_GPIO, {10'h0, gpv});
      bus(1'b1, `ADDR_CTRL, 16'h0000);
      $display("test gp done");
      bus(1'b1, `ADDR_IRQ_MASK, 16'h01FF);
      nz_val <= 24'($random(seed)) | 24'h000001;
      ticks(1023);
      chk("flags", {7'h0, all_f, pins}, 16'h0000);
      ticks(1);
      chk("flags", {7'h0, all_f, pins}, 16'h007F);
      bus(1'b0, `ADDR_STAT, 16'h007F);
      chk("irq", {15'h0, irq}, 16'h0001);
      bus(1'b1, `ADDR_IRQ_MASK, 16'h0000);
      idle(3);
      chk("irq", {15'h0, irq}, 16'h0000);
      bus(1'b1, `ADDR_IRQ_STATUS, 16'h01FF);
      bus(1'b1, `ADDR_IRQ_MASK, 16'h01FF);
      idle(3);
      chk("irq", {15'h0, irq}, 16'h0000);
      $display("test zero run done");
      zero_ch <= 8'hFF;
      slow <= 1'b1;
      ticks(1024);
      chk("flags", {7'h0, all_f, pins}, 16'h01FF);
      chk("irq", {15'h0, irq}, 16'h0001);
      bus(1'b1, `ADDR_CTRL, 16'(1 << `CTRL_POLARITY_BIT));
      idle(3);
      chk("flags", {7'h0, all_f, pins}, 16'h0000);
      bus(1'b0, `ADDR_CTRL, 16'h0002);
      $display("test polarity done");
      zero_ch <= 8'hFB;
      slow <= 1'b0;
      ticks(1);
      chk("flags", {7'h0, all_f, pins}, 16'h0104);
      zero_ch <= 8'hFF;
      ticks(1023);
      chk("flags", {7'h0, all_f, pins}, 16'h0104);
      $display("test restart done");
      test_done();
   end
endmodule
